//--- hw/tfe_defines.vh
/*
  Constants of the tap and free-fall event engines: register offsets,
  reset values, field positions, state codes and timing figures.
  Assumes it is included by the engine module of the same prefix only.
*/
// Overview of operation
// - Host writes 0x44 standby, then 0xC4 operate
// - Six tap direction enables, reset 0x3F
// - Single and double tap reports separately enabled
// - Second tap must end after gap count
// - Jerk index against doubled high threshold
// - Candidate when above low, below doubled high
// - Tap duration between low and high limit
// - Double tap total time above low capped
// - Latency caps samples above low per tap
// - Window bounds event; single reported at end
// - Pin control 0x30 gives enabled, high, latched
// - First pin routing: tap 0x04, fall 0x80
// - Tap sets status bit4, source bit3/bit2, direction
// - Reading release register unlatches interrupt, data meaningless
// - Fall control 0x80: enabled, latched, up/down, 12.5Hz
// - Fall threshold at four counts per g
// - Fall condition persists delay count at fall rate
// - Fall sets status bit4 and source bit7
// - Outputs valid some time after operate bit
// - Two output-rate periods before new settings apply
// - Pin control: bit3 pulse, bit4 polarity, bit5 enable
// - Release read also clears sources and status bit
`ifndef TFE_DEFINES_VH
`define TFE_DEFINES_VH

// Register offsets
`define TFE_A_DIR_SRC      8'h12
`define TFE_A_EVT_SRC      8'h13
`define TFE_A_STATUS       8'h15
`define TFE_A_UNLATCH      8'h17
`define TFE_A_MAIN         8'h18
`define TFE_A_RATE         8'h1A
`define TFE_A_PIN          8'h1C
`define TFE_A_DIR_MASK     8'h1E
`define TFE_A_ROUTE1       8'h1F
`define TFE_A_TAP_RPT      8'h24
`define TFE_A_GAP          8'h25
`define TFE_A_JERK_HI      8'h26
`define TFE_A_JERK_LO      8'h27
`define TFE_A_DUR          8'h28
`define TFE_A_TOTAL        8'h29
`define TFE_A_LATENCY      8'h2A
`define TFE_A_WINDOW       8'h2B
`define TFE_A_FALL_TH      8'h2C
`define TFE_A_FALL_CNT     8'h2D
`define TFE_A_FALL_CTL     8'h2E

// Reset values
`define TFE_R_ZERO         8'h00
`define TFE_R_RATE         8'h98
`define TFE_R_DIR_MASK     8'h3F
`define TFE_R_TAP_RPT      8'h03
`define TFE_R_GAP          8'h78
`define TFE_R_DUR          8'hA2
`define TFE_R_TOTAL        8'h24
`define TFE_R_LATENCY      8'h28
`define TFE_R_WINDOW       8'hA0

// Field positions
`define TFE_B_OPERATE      7
`define TFE_B_TAP_EN       2
`define TFE_B_SUMMARY      4
`define TFE_B_EVT_FALL     7
`define TFE_B_EVT_DOUBLE   3
`define TFE_B_EVT_SINGLE   2
`define TFE_B_PULSE        3
`define TFE_B_POLARITY     4
`define TFE_B_PIN_ON       5
`define TFE_B_ROUTE_TAP    2
`define TFE_B_ROUTE_FALL   7
`define TFE_B_RPT_SINGLE   0
`define TFE_B_RPT_DOUBLE   1
`define TFE_B_FALL_EN      7
`define TFE_B_FALL_RST_DB  3
`define TFE_F_TAP_RATE     4:3
`define TFE_F_FALL_RATE    2:0
`define TFE_F_MIN_DUR      2:0
`define TFE_F_MAX_DUR      7:3
`define TFE_F_JERK         15:8
`define TFE_F_FALL_MAG     15:9

// Rate dividers against the base sample tick
`define TFE_TAP_DIV_TOP    3'd5
`define TFE_FALL_DIV_TOP   3'd7
`define TFE_SETTLE_TICKS   2'd2

// Tap states
`define TFE_S_IDLE         3'd0
`define TFE_S_TAP1         3'd1
`define TFE_S_WAIT2        3'd2
`define TFE_S_TAP2         3'd3
`define TFE_S_REPORT       3'd4

// Timing
`define TFE_CLK_PERIOD_NS  8
`define TFE_PULSE_TIME_NS  50000

`endif

//--- hw/tfe_engines.v
/*
  Tap/double-tap and free-fall event engines with their register file,
  status and source registers and the first interrupt pin.
  Assumes a register port already decoded from the serial interface and a
  front end that presents three signed 16-bit samples on a 16g scale with a
  one-cycle base tick at 1600 Hz.
*/
`include "tfe_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module tfe_engines #(
  parameter integer PULSE_CYCLES = `TFE_PULSE_TIME_NS / `TFE_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_q,
  // Samples
  input  wire        base_tick,
  input  wire [15:0] acc_x,
  input  wire [15:0] acc_y,
  input  wire [15:0] acc_z,
  // Outputs
  output reg         data_valid_q,
  output reg         irq_pin_one_q
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  reg [7:0] main_control_q, engine_rate_control_q, irq_pin_control_q;
  reg [7:0] tap_direction_mask_q, irq_routing_first_pin_q;
  reg [7:0] tap_report_control_q, double_tap_gap_count_q;
  reg [7:0] jerk_high_threshold_q, jerk_low_threshold_q;
  reg [7:0] tap_duration_limits_q, double_tap_total_time_q;
  reg [7:0] tap_latency_count_q, tap_window_count_q;
  reg [7:0] fall_threshold_q, fall_delay_count_q, fall_engine_control_q;
  reg [7:0] tap_direction_source_q, event_source_q;

  wire release_rd = reg_rd && (reg_addr == `TFE_A_UNLATCH);

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      main_control_q          <= `TFE_R_ZERO;
      engine_rate_control_q   <= `TFE_R_RATE;
      irq_pin_control_q       <= `TFE_R_ZERO;
      tap_direction_mask_q    <= `TFE_R_DIR_MASK;
      irq_routing_first_pin_q <= `TFE_R_ZERO;
      tap_report_control_q    <= `TFE_R_TAP_RPT;
      double_tap_gap_count_q  <= `TFE_R_GAP;
      jerk_high_threshold_q   <= `TFE_R_ZERO;
      jerk_low_threshold_q    <= `TFE_R_ZERO;
      tap_duration_limits_q   <= `TFE_R_DUR;
      double_tap_total_time_q <= `TFE_R_TOTAL;
      tap_latency_count_q     <= `TFE_R_LATENCY;
      tap_window_count_q      <= `TFE_R_WINDOW;
      fall_threshold_q        <= `TFE_R_ZERO;
      fall_delay_count_q      <= `TFE_R_ZERO;
      fall_engine_control_q   <= `TFE_R_ZERO;
    end else if (reg_wr) begin
      case (reg_addr)
        `TFE_A_MAIN:     main_control_q          <= reg_wdata;
        `TFE_A_RATE:     engine_rate_control_q   <= reg_wdata;
        `TFE_A_PIN:      irq_pin_control_q       <= reg_wdata;
        `TFE_A_DIR_MASK: tap_direction_mask_q    <= reg_wdata;
        `TFE_A_ROUTE1:   irq_routing_first_pin_q <= reg_wdata;
        `TFE_A_TAP_RPT:  tap_report_control_q    <= reg_wdata;
        `TFE_A_GAP:      double_tap_gap_count_q  <= reg_wdata;
        `TFE_A_JERK_HI:  jerk_high_threshold_q   <= reg_wdata;
        `TFE_A_JERK_LO:  jerk_low_threshold_q    <= reg_wdata;
        `TFE_A_DUR:      tap_duration_limits_q   <= reg_wdata;
        `TFE_A_TOTAL:    double_tap_total_time_q <= reg_wdata;
        `TFE_A_LATENCY:  tap_latency_count_q     <= reg_wdata;
        `TFE_A_WINDOW:   tap_window_count_q      <= reg_wdata;
        `TFE_A_FALL_TH:  fall_threshold_q        <= reg_wdata;
        `TFE_A_FALL_CNT: fall_delay_count_q      <= reg_wdata;
        `TFE_A_FALL_CTL: fall_engine_control_q   <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire status_sum = |event_source_q;
  reg  [7:0] rd_mux;

  always @* begin
    case (reg_addr)
      `TFE_A_DIR_SRC:  rd_mux = tap_direction_source_q;
      `TFE_A_EVT_SRC:  rd_mux = event_source_q;
      `TFE_A_STATUS:   rd_mux = {3'h0, status_sum, 4'h0};
      `TFE_A_UNLATCH:  rd_mux = `TFE_R_ZERO;
      `TFE_A_MAIN:     rd_mux = main_control_q;
      `TFE_A_RATE:     rd_mux = engine_rate_control_q;
      `TFE_A_PIN:      rd_mux = irq_pin_control_q;
      `TFE_A_DIR_MASK: rd_mux = tap_direction_mask_q;
      `TFE_A_ROUTE1:   rd_mux = irq_routing_first_pin_q;
      `TFE_A_TAP_RPT:  rd_mux = tap_report_control_q;
      `TFE_A_GAP:      rd_mux = double_tap_gap_count_q;
      `TFE_A_JERK_HI:  rd_mux = jerk_high_threshold_q;
      `TFE_A_JERK_LO:  rd_mux = jerk_low_threshold_q;
      `TFE_A_DUR:      rd_mux = tap_duration_limits_q;
      `TFE_A_TOTAL:    rd_mux = double_tap_total_time_q;
      `TFE_A_LATENCY:  rd_mux = tap_latency_count_q;
      `TFE_A_WINDOW:   rd_mux = tap_window_count_q;
      `TFE_A_FALL_TH:  rd_mux = fall_threshold_q;
      `TFE_A_FALL_CNT: rd_mux = fall_delay_count_q;
      `TFE_A_FALL_CTL: rd_mux = fall_engine_control_q;
      default:         rd_mux = `TFE_R_ZERO;
    endcase
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= `TFE_R_ZERO;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Engine rates and settle after operate
  // ----------------------------------------------------------------
  wire operate = main_control_q[`TFE_B_OPERATE];
  reg  [6:0] div_q;
  wire [2:0] tap_sh  = `TFE_TAP_DIV_TOP - {1'b0, engine_rate_control_q[`TFE_F_TAP_RATE]};
  wire [2:0] fall_sh = `TFE_FALL_DIV_TOP - fall_engine_control_q[`TFE_F_FALL_RATE];
  wire [6:0] tap_msk  = (7'h01 << tap_sh) - 7'h01;
  wire [6:0] fall_msk = (7'h01 << fall_sh) - 7'h01;
  wire tap_tick  = base_tick && ((div_q & tap_msk) == 7'h00);
  wire fall_tick = base_tick && ((div_q & fall_msk) == 7'h00);
  reg  [1:0] settle_q;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_q        <= 7'h00;
      settle_q     <= 2'h0;
      data_valid_q <= 1'b0;
    end else begin
      if (base_tick) begin
        div_q <= div_q + 7'h01;
      end
      if (!operate) begin
        settle_q     <= 2'h0;
        data_valid_q <= 1'b0;
      end else if (tap_tick && !data_valid_q) begin
        settle_q <= settle_q + 2'h1;
        if (settle_q + 2'h1 == `TFE_SETTLE_TICKS) begin
          data_valid_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Jerk index and direction
  // ----------------------------------------------------------------
  reg  [15:0] px_q, py_q, pz_q;
  wire [15:0] dx = acc_x - px_q;
  wire [15:0] dy = acc_y - py_q;
  wire [15:0] dz = acc_z - pz_q;
  wire [15:0] ax = dx[15] ? (16'h0000 - dx) : dx;
  wire [15:0] ay = dy[15] ? (16'h0000 - dy) : dy;
  wire [15:0] az = dz[15] ? (16'h0000 - dz) : dz;
  // upper eight bits of 16g data
  wire [7:0]  jx = ax[`TFE_F_JERK];
  wire [7:0]  jy = ay[`TFE_F_JERK];
  wire [7:0]  jz = az[`TFE_F_JERK];
  reg  [7:0]  jerk_index;
  reg  [5:0]  dir_hot;

  always @* begin
    if (jx >= jy && jx >= jz) begin
      jerk_index = jx;
      dir_hot    = dx[15] ? 6'h20 : 6'h10;
    end else if (jy >= jz) begin
      jerk_index = jy;
      dir_hot    = dy[15] ? 6'h08 : 6'h04;
    end else begin
      jerk_index = jz;
      dir_hot    = dz[15] ? 6'h02 : 6'h01;
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      px_q <= 16'h0000;
      py_q <= 16'h0000;
      pz_q <= 16'h0000;
    end else if (tap_tick) begin
      px_q <= acc_x;
      py_q <= acc_y;
      pz_q <= acc_z;
    end
  end

  // doubled high threshold 0 to 510
  wire [8:0] jerk_hi2   = {jerk_high_threshold_q, 1'b0};
  wire       above_low  = jerk_index > jerk_low_threshold_q;
  wire       in_band    = above_low && ({1'b0, jerk_index} < jerk_hi2);
  wire       dir_ok     = |(dir_hot & tap_direction_mask_q[5:0]);
  wire       candidate  = in_band && dir_ok;
  wire [7:0] min_dur    = {5'h00, tap_duration_limits_q[`TFE_F_MIN_DUR]};
  wire [7:0] max_dur    = {3'h0, tap_duration_limits_q[`TFE_F_MAX_DUR]};

  // ----------------------------------------------------------------
  // Tap state machine
  // ----------------------------------------------------------------
  reg [2:0] tap_st_q;
  reg [7:0] win_q, dur_q, lat_q, tot_q;
  reg [5:0] dir_q;
  reg       tap_single_ev, tap_double_ev;
  wire      tap_run = operate && data_valid_q && main_control_q[`TFE_B_TAP_EN];
  wire      dur_ok  = (dur_q >= min_dur) && (dur_q <= max_dur);
  wire [8:0] tot_sum = {1'b0, tot_q} + {1'b0, dur_q};

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tap_st_q      <= `TFE_S_IDLE;
      win_q         <= 8'h00;
      dur_q         <= 8'h00;
      lat_q         <= 8'h00;
      tot_q         <= 8'h00;
      dir_q         <= 6'h00;
      tap_single_ev <= 1'b0;
      tap_double_ev <= 1'b0;
    end else begin
      tap_single_ev <= 1'b0;
      tap_double_ev <= 1'b0;
      if (!tap_run) begin
        tap_st_q <= `TFE_S_IDLE;
      end else if (tap_tick) begin
        if (win_q != 8'hFF) begin
          win_q <= win_q + 8'h01;
        end
        case (tap_st_q)
          `TFE_S_IDLE: begin
            if (candidate) begin
              // gap counts from first tap start
              win_q    <= 8'h01;
              dur_q    <= 8'h01;
              lat_q    <= 8'h01;
              tot_q    <= 8'h00;
              dir_q    <= dir_hot;
              tap_st_q <= `TFE_S_TAP1;
            end
          end
          `TFE_S_TAP1, `TFE_S_TAP2: begin
            if (above_low) begin
              dur_q <= dur_q + 8'h01;
              lat_q <= lat_q + 8'h01;
              if (lat_q >= tap_latency_count_q) begin
                tap_st_q <= `TFE_S_IDLE;
              end
            end else if (tap_st_q == `TFE_S_TAP1) begin
              tap_st_q <= dur_ok ? `TFE_S_WAIT2 : `TFE_S_IDLE;
              tot_q    <= dur_q;
            end else if (dur_ok && win_q > double_tap_gap_count_q &&
                         tot_sum <= {1'b0, double_tap_total_time_q}) begin
              tap_double_ev <= tap_report_control_q[`TFE_B_RPT_DOUBLE];
              tap_st_q      <= `TFE_S_REPORT;
            end else begin
              tap_st_q <= `TFE_S_WAIT2;
            end
            if (tap_st_q == `TFE_S_TAP2 && win_q >= tap_window_count_q) begin
              tap_single_ev <= tap_report_control_q[`TFE_B_RPT_SINGLE];
              tap_st_q      <= `TFE_S_IDLE;
            end
          end
          `TFE_S_WAIT2: begin
            if (win_q >= tap_window_count_q) begin
              tap_single_ev <= tap_report_control_q[`TFE_B_RPT_SINGLE];
              tap_st_q      <= `TFE_S_IDLE;
            end else if (candidate) begin
              dur_q    <= 8'h01;
              lat_q    <= 8'h01;
              tap_st_q <= `TFE_S_TAP2;
            end
          end
          `TFE_S_REPORT: begin
            tap_st_q <= `TFE_S_IDLE;
          end
          default: tap_st_q <= `TFE_S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Free-fall engine
  // ----------------------------------------------------------------
  wire [15:0] mx = acc_x[15] ? (16'h0000 - acc_x) : acc_x;
  wire [15:0] my = acc_y[15] ? (16'h0000 - acc_y) : acc_y;
  wire [15:0] mz = acc_z[15] ? (16'h0000 - acc_z) : acc_z;
  wire [7:0] fx = {1'b0, mx[`TFE_F_FALL_MAG]};
  wire [7:0] fy = {1'b0, my[`TFE_F_FALL_MAG]};
  wire [7:0] fz = {1'b0, mz[`TFE_F_FALL_MAG]};
  wire falling = (fx < fall_threshold_q) && (fy < fall_threshold_q) &&
                 (fz < fall_threshold_q);
  wire fall_run = operate && data_valid_q && fall_engine_control_q[`TFE_B_FALL_EN];
  reg  [7:0] fall_cnt_q;
  reg        fall_ev;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fall_cnt_q <= 8'h00;
      fall_ev    <= 1'b0;
    end else begin
      fall_ev <= 1'b0;
      if (!fall_run) begin
        fall_cnt_q <= 8'h00;
      end else if (fall_tick) begin
        if (falling) begin
          if (fall_cnt_q != 8'hFF) begin
            fall_cnt_q <= fall_cnt_q + 8'h01;
          end
          if (fall_cnt_q + 8'h01 == fall_delay_count_q) begin
            fall_ev <= 1'b1;
          end
        end else if (fall_engine_control_q[`TFE_B_FALL_RST_DB]) begin
          fall_cnt_q <= 8'h00;
        end else if (fall_cnt_q != 8'h00) begin
          fall_cnt_q <= fall_cnt_q - 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sources, status and release
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      event_source_q         <= `TFE_R_ZERO;
      tap_direction_source_q <= `TFE_R_ZERO;
    end else begin
      // release read clears sources, events win
      if (release_rd) begin
        event_source_q         <= `TFE_R_ZERO;
        tap_direction_source_q <= `TFE_R_ZERO;
      end
      if (tap_single_ev || tap_double_ev) begin
        event_source_q[`TFE_B_EVT_SINGLE] <= tap_single_ev;
        event_source_q[`TFE_B_EVT_DOUBLE] <= tap_double_ev;
        tap_direction_source_q            <= {2'h0, dir_q};
      end
      if (fall_ev) begin
        event_source_q[`TFE_B_EVT_FALL] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // First interrupt pin
  // ----------------------------------------------------------------
  // routing of tap and fall
  wire routed = (irq_routing_first_pin_q[`TFE_B_ROUTE_TAP] &&
                 (event_source_q[`TFE_B_EVT_SINGLE] ||
                  event_source_q[`TFE_B_EVT_DOUBLE])) ||
                (irq_routing_first_pin_q[`TFE_B_ROUTE_FALL] &&
                 event_source_q[`TFE_B_EVT_FALL]);
  wire new_ev = (irq_routing_first_pin_q[`TFE_B_ROUTE_TAP] &&
                 (tap_single_ev || tap_double_ev)) ||
                (irq_routing_first_pin_q[`TFE_B_ROUTE_FALL] && fall_ev);
  reg  [12:0] pulse_q;
  reg         active;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pulse_q <= 13'h0000;
    end else if (new_ev) begin
      pulse_q <= PULSE_CYCLES[12:0];
    end else if (pulse_q != 13'h0000) begin
      pulse_q <= pulse_q - 13'h0001;
    end
  end

  always @* begin
    if (irq_pin_control_q[`TFE_B_PULSE]) begin
      active = pulse_q != 13'h0000;
    end else begin
      active = routed;
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_pin_one_q <= 1'b0;
    end else begin
      // enable and polarity on the pin
      irq_pin_one_q <= (irq_pin_control_q[`TFE_B_PIN_ON] && active) ~^
                       irq_pin_control_q[`TFE_B_POLARITY];
    end
  end

endmodule

`default_nettype wire

//--- sim/tb_tfe_engines.sv
/*
  Self-checking bench: reset values, latched free fall, disabled pin,
  single and double tap, pulse mode.
  Assumes the checker is bound and the host model drives the port.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_tfe_engines;
  logic        ref_clk;
  logic        reset;
  logic        base_tick;
  logic [15:0] acc;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata_q;
  logic        data_valid_q;
  logic        irq_pin_one_q;
  logic [7:0]  d;
  int          err_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  logic [15:0] rows [0:10] = '{16'h1A98, 16'h1E3F, 16'h2403, 16'h2578, 16'h28A2,
    16'h2924, 16'h2A28, 16'h2BA0, 16'h1800, 16'h2C00, 16'h0500};
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  tfe_host host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
  tfe_engines #(.PULSE_CYCLES(20)) dut (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .base_tick(base_tick), .acc_x(acc), .acc_y(acc),
    .acc_z(acc), .data_valid_q(data_valid_q), .irq_pin_one_q(irq_pin_one_q));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      base_tick = 1'b1;
      @(negedge ref_clk);
      base_tick = 1'b0;
      repeat (2) @(negedge ref_clk);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    reset = 1'b1;
    base_tick = 1'b0;
    acc = 16'h4000;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({7'h00, irq_pin_one_q}, 8'h01);
    for (int i = 0; i < 11; i++) begin
      host.rd(rows[i][15:8], d);
      chk(d, rows[i][7:0]);
    end
    $display("reset values done");
    host.wr(8'h18, 8'h44);
    host.wr(8'h1C, 8'h30);
    host.wr(8'h1F, 8'h80);
    host.wr(8'h2C, 8'h02);
    host.rd(8'h2C, d);
    chk(d, 8'h02);
    host.wr(8'h2D, 8'h04);
    host.wr(8'h2E, 8'h87);
    host.wr(8'h18, 8'hC4);
    tick(9);
    chk({7'h00, data_valid_q}, 8'h01);
    acc = 16'h0000;
    tick(3);
    chk({7'h00, irq_pin_one_q}, 8'h00);
    tick(1);
    acc = 16'h4000;
    repeat (4) @(negedge ref_clk);
    chk({7'h00, irq_pin_one_q}, 8'h01);
    host.rd(8'h13, d);
    chk(d, 8'h80);
    host.rd(8'h15, d);
    chk(d, 8'h10);
    host.rd(8'h17, d);
    @(negedge ref_clk);
    chk({7'h00, irq_pin_one_q}, 8'h00);
    host.rd(8'h13, d);
    chk(d, 8'h00);
    host.rd(8'h15, d);
    chk(d, 8'h00);
    $display("latched fall done");
    host.wr(8'h1C, 8'h10);
    tick(4);
    acc = 16'h0000;
    tick(4);
    acc = 16'h4000;
    repeat (4) @(negedge ref_clk);
    chk({7'h00, irq_pin_one_q}, 8'h00);
    host.rd(8'h13, d);
    chk(d, 8'h80);
    host.rd(8'h17, d);
    $display("disabled pin done");
    host.wr(8'h18, 8'h44);
    host.wr(8'h1F, 8'h04);
    host.wr(8'h1C, 8'h30);
    host.wr(8'h26, 8'h33);
    host.wr(8'h27, 8'h07);
    host.wr(8'h18, 8'hC4);
    tick(8);
    acc = 16'h4800;
    tick(4);
    acc = 16'h5000;
    tick(4);
    tick(600);
    chk({7'h00, irq_pin_one_q}, 8'h00);
    tick(40);
    chk({7'h00, irq_pin_one_q}, 8'h01);
    host.rd(8'h13, d);
    chk(d, 8'h04);
    host.rd(8'h12, d);
    chk(d, 8'h10);
    host.rd(8'h15, d);
    chk(d, 8'h10);
    host.rd(8'h17, d);
    $display("single tap done");
    acc = 16'h5800;
    tick(4);
    acc = 16'h6000;
    tick(8);
    tick(508);
    chk({7'h00, irq_pin_one_q}, 8'h00);
    acc = 16'h6800;
    tick(4);
    acc = 16'h7000;
    tick(4);
    tick(8);
    chk({7'h00, irq_pin_one_q}, 8'h01);
    host.rd(8'h13, d);
    chk(d, 8'h08);
    host.rd(8'h12, d);
    chk(d, 8'h10);
    host.rd(8'h17, d);
    $display("double tap done");
    host.wr(8'h1C, 8'h38);
    host.wr(8'h1F, 8'h80);
    acc = 16'h0000;
    tick(4);
    chk({7'h00, irq_pin_one_q}, 8'h01);
    repeat (24) @(negedge ref_clk);
    chk({7'h00, irq_pin_one_q}, 8'h00);
    host.rd(8'h17, d);
    $display("pulse mode done");
    conclude();
  end
endmodule
`default_nettype wire

//--- sim/tfe_host.sv
/*
  Host model on the register port, launching strobes on falling edges.
  Assumes its tasks are called only after reset has been released.
*/
`timescale 1ns/1ps
`default_nettype none
module tfe_host (
  // Clock
  input  wire logic       ref_clk,
  // Register port
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  input  wire logic [7:0] reg_rdata_q
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask
  // One-cycle read, data taken next cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rdata_q;
  endtask
endmodule
`default_nettype wire

//--- sim/tfe_sva.sv
/*
  Port checker for the tap and free-fall engines.
  Assumes a bind onto tfe_engines and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tfe_sva #(
  parameter integer PULSE_CYCLES = 20
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_q,
  // Samples and outputs
  input wire logic       base_tick,
  input wire logic       data_valid_q,
  input wire logic       irq_pin_one_q
);
  logic [7:0] pin_q;
  logic       op_q;
  logic [3:0] tick_n_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Shadow of pin control and operate bit
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_q <= 8'h00;
      op_q <= 1'b0;
      tick_n_q <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == 8'h1C) pin_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'h18) op_q <= reg_wdata[7];
      if (!op_q) tick_n_q <= 4'h0;
      else if (base_tick && tick_n_q != 4'hF) tick_n_q <= tick_n_q + 4'h1;
    end
  end
  sequence quiet_rel_s;
    !base_tick [*4] ##1 (reg_rd && reg_addr == 8'h17 && !base_tick);
  endsequence
  rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (reg_rd && reg_addr < 8'h12 |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  reg_readback_a: assert property (reg_wr && reg_addr == 8'h2C ##2
    reg_rd && reg_addr == 8'h2C |=> reg_rdata_q == $past(reg_wdata, 3))
    else $error("threshold readback wrong");
  valid_delay_a: assert property ($rose(data_valid_q) |-> tick_n_q >= 4'h2)
    else $error("outputs valid too early");
  idle_pin_a: assert property (!pin_q[5] ##1 (!pin_q[5] && $stable(pin_q))
    |-> irq_pin_one_q == !pin_q[4]) else $error("disabled pin not at idle level");
  pin_cause_a: assert property ($rose(irq_pin_one_q) && pin_q == 8'h30
    && $past(pin_q) == 8'h30 |-> $past(base_tick, 3)) else $error("pin rose without tick");
  unlatch_pin_a: assert property (quiet_rel_s ##0 pin_q == 8'h30 ##1 !base_tick
    |=> irq_pin_one_q == 1'b0) else $error("pin not released");
  clear_src_a: assert property (quiet_rel_s ##1 !base_tick [*2] ##1
    (reg_rd && reg_addr == 8'h13 && !base_tick) |=> reg_rdata_q == 8'h00)
    else $error("sources not cleared");
endmodule
bind tfe_engines tfe_sva #(.PULSE_CYCLES(PULSE_CYCLES)) u_sva (.ref_clk(ref_clk),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .base_tick(base_tick),
  .data_valid_q(data_valid_q), .irq_pin_one_q(irq_pin_one_q));
`default_nettype wire
